// [src/flash_cmd_map.vh]
// Register offsets, field positions, command codes and reset values of the flash
// command, status and protection block.
// Assumes byte addresses on a 32-bit APB with one aligned word per register.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// Register byte offsets.
`define OFS_CLOCK_DIVIDER    8'h00
`define OFS_PROTECTION       8'h04
`define OFS_STATUS           8'h08
`define OFS_COMMAND          8'h0c
`define OFS_TARGET_ADDRESS   8'h10
`define OFS_TARGET_DATA      8'h14
`define OFS_SECURITY         8'h18

// Status register bit positions.
`define BIT_BUFFER_EMPTY     7
`define BIT_COMMAND_COMPLETE 6
`define BIT_PROTECT_VIOL     5
`define BIT_ACCESS_ERROR     4
`define BIT_BLANK_VERIFIED   2

// Protection register fields.
`define BIT_PROTECT_DISABLE  0
`define PROTECT_SELECT_MSB   7
`define PROTECT_SELECT_LSB   1

// Clock divider register fields.
`define BIT_DIVIDER_LOADED   7
`define BIT_PREDIVIDE_EIGHT  6
`define DIVIDER_MSB          5

// Command codes.
`define CMD_BLANK_CHECK      8'h05
`define CMD_BYTE_PROGRAM     8'h20
`define CMD_BURST_PROGRAM    8'h25
`define CMD_PAGE_ERASE       8'h40
`define CMD_MASS_ERASE       8'h41

// Reset values and encodings.
`define PROTECTION_RESET     8'hff
`define SECURITY_RESET       2'h0
`define SECURITY_UNSECURED   2'h2
`define PREDIVIDE_LAST       3'h7

`endif

// [src/flash_command_status_protect.v]
// Command launch, status flags, protection and flash clock divider of an on-chip
// flash controller, with an APB register slave.
// Assumes the flash array, the debug port and the stop logic run on pclk, and that
// the nonvolatile copies are stable while presetn is low and just after it.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_map.vh"

module flash_command_status_protect #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset.
  input  wire                  pclk,
  input  wire                  presetn,
  // APB slave.
  input  wire [7:0]            paddr,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // Nonvolatile copies presented by the array during reset.
  input  wire [7:0]            nonvolatile_protection_copy,
  input  wire [1:0]            nonvolatile_security_copy,
  // Background debug access to the protection register.
  input  wire                  debug_protection_write,
  input  wire [7:0]            debug_protection_data,
  // System stop entry.
  input  wire                  stop_entry,
  // Flash array.
  input  wire                  array_done,
  input  wire                  array_blank,
  output reg                   array_start,
  output reg                   array_abort,
  output reg  [7:0]            array_command,
  output reg  [ADDR_WIDTH-1:0] array_address,
  output reg  [7:0]            array_data,
  // Timing tick and security state.
  output reg                   flash_clock_tick,
  output reg  [1:0]            security_state
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decoding.

  function is_legal;
    input [7:0] code;
    begin
      is_legal = (code == `CMD_BLANK_CHECK) || (code == `CMD_BYTE_PROGRAM) ||
                 (code == `CMD_BURST_PROGRAM) || (code == `CMD_PAGE_ERASE) ||
                 (code == `CMD_MASS_ERASE);
    end
  endfunction

  function is_program_erase;
    input [7:0] code;
    begin
      is_program_erase = is_legal(code) && (code != `CMD_BLANK_CHECK);
    end
  endfunction

  function ends_blank_check;
    input       running;
    input       done;
    input [7:0] code;
    begin
      ends_blank_check = running && done && (code == `CMD_BLANK_CHECK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  reg [7:0]            protection_register;
  reg                  loaded;
  reg                  state;
  reg [7:0]            run_command;
  reg                  command_buffer_empty_flag;
  reg                  command_complete_flag;
  reg                  protection_violation_flag;
  reg                  access_error_flag;
  reg                  blank_verified_flag;
  reg [7:0]            command_register;
  reg [ADDR_WIDTH-1:0] target_address;
  reg [7:0]            target_data;
  reg                  command_written;
  reg                  divider_loaded;
  reg                  predivide_by_eight;
  reg [5:0]            divider;
  reg [2:0]            predivide_count;
  reg [5:0]            divide_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire write_access = psel && penable && pwrite;
  wire setup_phase  = psel && !penable;
  wire wr_status    = write_access && (paddr == `OFS_STATUS);
  wire wr_protect   = write_access && (paddr == `OFS_PROTECTION);
  wire wr_divider   = write_access && (paddr == `OFS_CLOCK_DIVIDER);
  wire wr_sequence  = write_access && ((paddr == `OFS_COMMAND) ||
                      (paddr == `OFS_TARGET_ADDRESS) || (paddr == `OFS_TARGET_DATA));

  wire       protect_disable = protection_register[`BIT_PROTECT_DISABLE];
  wire [6:0] protect_select  =
             protection_register[`PROTECT_SELECT_MSB:`PROTECT_SELECT_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Launch checks.

  // Page bits drop out: the top seven address bits above the selected value are
  // guarded, which is the same as an address beyond the selected page's end.
  wire addr_protected = target_address[ADDR_WIDTH-1 -: 7] > protect_select;
  wire launch = wr_status && pwdata[`BIT_BUFFER_EMPTY] && command_buffer_empty_flag;
  wire burst_chain = (command_register == `CMD_BURST_PROGRAM) &&
                     (run_command == `CMD_BURST_PROGRAM);
  wire sequence_bad = !command_written ||
                      ((state == ST_RUN) && !burst_chain);
  wire launch_access_error = launch && (!is_legal(command_register) ||
                             (is_program_erase(command_register) && !divider_loaded) ||
                             sequence_bad);
  wire launch_violation = launch && !launch_access_error &&
                          is_program_erase(command_register) && !protect_disable &&
                          ((command_register == `CMD_MASS_ERASE) || addr_protected);
  // A launch while an error flag stands is ignored until software clears it.
  wire accept = launch && !launch_access_error && !launch_violation &&
                !access_error_flag && !protection_violation_flag;
  wire stop_abort = stop_entry && ((state == ST_RUN) || !command_buffer_empty_flag);
  wire sequence_error = wr_sequence && !command_buffer_empty_flag;
  wire issue = !stop_abort && !command_buffer_empty_flag &&
               ((state == ST_IDLE) || array_done);
  // A stray done pulse while idle is ignored, so it can never set the blank flag
  // or unsecure the device.
  wire blank_check_done = ends_blank_check(state == ST_RUN, array_done, run_command);

  reg next_state;
  reg next_buffer_empty;

  always @* begin
    next_state = state;
    next_buffer_empty = command_buffer_empty_flag;
    if (stop_abort) begin
      next_state = ST_IDLE;
      next_buffer_empty = 1'b1;
    end else begin
      if (issue) begin
        next_state = ST_RUN;
        next_buffer_empty = 1'b1;
      end else if (array_done) begin
        next_state = ST_IDLE;
      end
      if (accept) begin
        next_buffer_empty = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer and status flags.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      run_command <= 8'h00;
      command_buffer_empty_flag <= 1'b1;
      command_complete_flag <= 1'b1;
      protection_violation_flag <= 1'b0;
      access_error_flag <= 1'b0;
      blank_verified_flag <= 1'b0;
      command_written <= 1'b0;
      array_start <= 1'b0;
      array_abort <= 1'b0;
      array_command <= 8'h00;
      array_address <= {ADDR_WIDTH{1'b0}};
      array_data <= 8'h00;
    end else begin
      state <= next_state;
      command_buffer_empty_flag <= next_buffer_empty;
      command_complete_flag <= next_buffer_empty && (next_state == ST_IDLE);
      array_start <= issue;
      array_abort <= stop_abort;
      if (issue) begin
        run_command <= command_register;
        array_command <= command_register;
        array_address <= target_address;
        array_data <= target_data;
      end
      // Set wins over a clear in the same cycle.
      protection_violation_flag <= launch_violation ||
        (protection_violation_flag && !(wr_status && pwdata[`BIT_PROTECT_VIOL]));
      access_error_flag <= launch_access_error || stop_abort || sequence_error ||
        (access_error_flag && !(wr_status && pwdata[`BIT_ACCESS_ERROR]));
      if (blank_check_done) begin
        blank_verified_flag <= array_blank;
      end else if (accept) begin
        blank_verified_flag <= 1'b0;
      end
      if (launch) begin
        command_written <= 1'b0;
      end else if (write_access && paddr == `OFS_COMMAND && command_buffer_empty_flag) begin
        command_written <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command, target and divider registers.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_register <= 8'h00;
      target_address <= {ADDR_WIDTH{1'b0}};
      target_data <= 8'h00;
      divider_loaded <= 1'b0;
      predivide_by_eight <= 1'b0;
      divider <= 6'h00;
    end else begin
      // Writes while the buffer is full are dropped so a queued burst stays intact.
      if (command_buffer_empty_flag && write_access) begin
        if (paddr == `OFS_COMMAND) begin
          command_register <= pwdata[7:0];
        end else if (paddr == `OFS_TARGET_ADDRESS) begin
          target_address <= pwdata[ADDR_WIDTH-1:0];
        end else if (paddr == `OFS_TARGET_DATA) begin
          target_data <= pwdata[7:0];
        end
      end
      if (wr_divider) begin
        divider_loaded <= 1'b1;
        predivide_by_eight <= pwdata[`BIT_PREDIVIDE_EIGHT];
        divider <= pwdata[`DIVIDER_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protection register and security state.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded <= 1'b0;
      protection_register <= `PROTECTION_RESET;
      security_state <= `SECURITY_RESET;
    end else begin
      if (!loaded) begin
        loaded <= 1'b1;
        protection_register <= nonvolatile_protection_copy;
        security_state <= nonvolatile_security_copy;
      end else if (debug_protection_write) begin
        protection_register <= debug_protection_data;
      end else if (wr_protect && !protect_disable) begin
        if (pwdata[`PROTECT_SELECT_MSB:`PROTECT_SELECT_LSB] <= protect_select) begin
          protection_register <= {pwdata[`PROTECT_SELECT_MSB:`PROTECT_SELECT_LSB],
                                  1'b0};
        end
      end
      if (loaded && blank_check_done && array_blank) begin
        security_state <= `SECURITY_UNSECURED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash timing tick.

  wire predivide_tick = !predivide_by_eight || (predivide_count == `PREDIVIDE_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      predivide_count <= 3'h0;
      divide_count <= 6'h00;
      flash_clock_tick <= 1'b0;
    end else if (!divider_loaded || wr_divider) begin
      predivide_count <= 3'h0;
      divide_count <= 6'h00;
      flash_clock_tick <= 1'b0;
    end else begin
      predivide_count <= predivide_count + 3'h1;
      flash_clock_tick <= 1'b0;
      if (predivide_tick) begin
        if (divide_count == divider) begin
          divide_count <= 6'h00;
          flash_clock_tick <= 1'b1;
        end else begin
          divide_count <= divide_count + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  reg [7:0] read_value;
  reg       read_mapped;

  always @* begin
    read_value = 8'h00;
    read_mapped = 1'b1;
    if (paddr == `OFS_CLOCK_DIVIDER) begin
      read_value = {divider_loaded, predivide_by_eight, divider};
    end else if (paddr == `OFS_PROTECTION) begin
      read_value = protection_register;
    end else if (paddr == `OFS_STATUS) begin
      read_value = {command_buffer_empty_flag, command_complete_flag,
                    protection_violation_flag, access_error_flag, 1'b0,
                    blank_verified_flag, 2'b00};
    end else if (paddr == `OFS_COMMAND) begin
      read_value = command_register;
    end else if (paddr == `OFS_TARGET_ADDRESS) begin
      read_value = target_address[7:0];
    end else if (paddr == `OFS_TARGET_DATA) begin
      read_value = target_data;
    end else if (paddr == `OFS_SECURITY) begin
      read_value = {6'h00, security_state};
    end else begin
      read_mapped = 1'b0;
    end
  end

  // Read data and error are captured in the setup cycle, so every access has
  // no wait state and all bus outputs come from flip-flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_phase) begin
        pslverr <= !read_mapped;
        if (paddr == `OFS_TARGET_ADDRESS) begin
          prdata <= {{(32-ADDR_WIDTH){1'b0}}, target_address};
        end else begin
          prdata <= {24'h000000, read_value};
        end
      end
    end
  end

endmodule

`default_nettype wire

// [test/flash_command_status_protect_properties.sv]
// Concurrent checks on the ports of the flash command block.
// Assumes the bench answers each started command with one array_done pulse.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_map.vh"
module flash_command_status_protect_checker #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus side.
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Array and system side.
  input wire logic        stop_entry,
  input wire logic        array_done,
  input wire logic        array_blank,
  input wire logic        array_start,
  input wire logic        array_abort,
  input wire logic [7:0]  array_command,
  input wire logic [1:0]  security_state
);
  logic       busy;
  logic [7:0] last_cmd;
  // Busy is tracked from the array handshake alone, so it may lag the launch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      last_cmd <= 8'h00;
    end else if (array_start) begin
      busy     <= 1'b1;
      last_cmd <= array_command;
    end else if (array_done || array_abort) begin
      busy     <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_status_read;
    psel && penable && !pwrite && paddr == `OFS_STATUS;
  endsequence
  sequence s_blank_done;
    busy && array_done && array_blank && last_cmd == `CMD_BLANK_CHECK;
  endsequence
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_unmapped_error: assert property (psel && !penable && paddr > `OFS_SECURITY ##1 penable
    |-> pslverr) else $error("unmapped access without error");
  a_start_one_cycle: assert property (array_start |=> !array_start)
    else $error("array start longer than one cycle");
  a_start_legal_code: assert property (array_start |-> array_command inside
    {`CMD_BLANK_CHECK, `CMD_BYTE_PROGRAM, `CMD_BURST_PROGRAM, `CMD_PAGE_ERASE, `CMD_MASS_ERASE})
    else $error("array started with an illegal code");
  a_abort_one_cycle: assert property (array_abort |=> !array_abort)
    else $error("abort longer than one cycle");
  a_stop_aborts: assert property (stop_entry && busy && !array_done |=> array_abort)
    else $error("stop while busy did not abort");
  a_blank_unsecures: assert property (s_blank_done |=>
    security_state == `SECURITY_UNSECURED) else $error("blank check left device secure");
  // The first edge after reset loads the nonvolatile copy, so it is left out.
  a_security_cause: assert property ($past(presetn) && $past(presetn, 2) &&
    security_state != $past(security_state)
    |-> $past(array_done) && security_state == `SECURITY_UNSECURED)
    else $error("security state changed without a blank check");
  a_busy_not_done: assert property (busy ##0 s_status_read |->
    !prdata[`BIT_COMMAND_COMPLETE]) else $error("complete flag set while busy");
endmodule
bind flash_command_status_protect flash_command_status_protect_checker #(
  .ADDR_WIDTH(ADDR_WIDTH)
) i_checker (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_entry(stop_entry), .array_done(array_done), .array_blank(array_blank),
  .array_start(array_start), .array_abort(array_abort), .array_command(array_command),
  .security_state(security_state)
);
`default_nettype wire

// [test/flash_command_status_protect_test.sv]
// Self-checking bench for the flash command, status and protection block.
// Assumes a zero-wait APB slave; the bench plays the flash array itself.
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_map.vh"
module flash_command_status_protect_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  nonvolatile_protection_copy = 8'h80;
  logic [1:0]  nonvolatile_security_copy = 2'h0;
  logic        debug_protection_write = 1'b0;
  logic [7:0]  debug_protection_data = 8'h00;
  logic        stop_entry = 1'b0;
  logic        array_done = 1'b0;
  logic        array_blank = 1'b0;
  logic        array_start;
  logic        array_abort;
  logic [7:0]  array_command;
  logic [15:0] array_address;
  logic [7:0]  array_data;
  logic        flash_clock_tick;
  logic [1:0]  security_state;
  logic [31:0] rd;
  logic        seen;
  integer      errors = 0;
  integer      n_checks = 0;
  always #12.5 pclk = ~pclk;
  flash_command_status_protect #(.ADDR_WIDTH(16)) i_flash_command_status_protect (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nonvolatile_protection_copy(nonvolatile_protection_copy),
    .nonvolatile_security_copy(nonvolatile_security_copy),
    .debug_protection_write(debug_protection_write),
    .debug_protection_data(debug_protection_data), .stop_entry(stop_entry),
    .array_done(array_done), .array_blank(array_blank), .array_start(array_start),
    .array_abort(array_abort), .array_command(array_command),
    .array_address(array_address), .array_data(array_data),
    .flash_clock_tick(flash_clock_tick), .security_state(security_state));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each transfer starts on a fresh edge so no strobe is driven twice at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic launch(input logic [7:0] cmd, input logic [15:0] a);
    apb(1'b1, `OFS_TARGET_ADDRESS, {16'h0, a});
    apb(1'b1, `OFS_TARGET_DATA, 32'h5a);
    apb(1'b1, `OFS_COMMAND, {24'h0, cmd});
    apb(1'b1, `OFS_STATUS, 32'h80);
  endtask
  task automatic wait_start;
    integer n;
    seen = 1'b0;
    for (n = 0; n < 20 && !seen; n = n + 1) begin
      @(negedge pclk);
      seen = (array_start === 1'b1);
    end
  endtask
  task automatic finish_cmd(input logic blank);
    @(posedge pclk);
    array_done  <= 1'b1;
    array_blank <= blank;
    @(posedge pclk);
    array_done  <= 1'b0;
  endtask
  task automatic debug_write(input logic [7:0] d);
    @(posedge pclk);
    debug_protection_write <= 1'b1;
    debug_protection_data  <= d;
    @(posedge pclk);
    debug_protection_write <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_errors;
    expect_reg(`OFS_STATUS, 32'hc0);
    expect_reg(`OFS_PROTECTION, 32'h80);
    launch(`CMD_BYTE_PROGRAM, 16'h1000);
    expect_reg(`OFS_STATUS, 32'hd0);
    apb(1'b1, `OFS_STATUS, 32'h00);
    expect_reg(`OFS_STATUS, 32'hd0);
    apb(1'b1, `OFS_STATUS, 32'h10);
    expect_reg(`OFS_STATUS, 32'hc0);
    apb(1'b1, `OFS_CLOCK_DIVIDER, 32'h01);
    apb(1'b0, 8'h40, 32'h0);
    launch(8'h30, 16'h1000);
    wait_start;
    check({31'h0, seen}, 32'h0);
    expect_reg(`OFS_STATUS, 32'hd0);
    apb(1'b1, `OFS_STATUS, 32'h10);
    $display("error flag test done");
  endtask
  task automatic t_protection;
    apb(1'b1, `OFS_PROTECTION, 32'h60);
    expect_reg(`OFS_PROTECTION, 32'h60);
    apb(1'b1, `OFS_PROTECTION, 32'h70);
    expect_reg(`OFS_PROTECTION, 32'h60);
    apb(1'b1, `OFS_PROTECTION, 32'h21);
    expect_reg(`OFS_PROTECTION, 32'h20);
    launch(`CMD_BYTE_PROGRAM, 16'hff00);
    wait_start;
    check({31'h0, seen}, 32'h0);
    expect_reg(`OFS_STATUS, 32'he0);
    apb(1'b1, `OFS_STATUS, 32'h20);
    launch(`CMD_MASS_ERASE, 16'h0000);
    expect_reg(`OFS_STATUS, 32'he0);
    apb(1'b1, `OFS_STATUS, 32'h20);
    launch(`CMD_BYTE_PROGRAM, 16'h1000);
    wait_start;
    check({16'h0, array_address}, 32'h1000);
    finish_cmd(1'b0);
    expect_reg(`OFS_STATUS, 32'hc0);
    $display("protection test done");
  endtask
  task automatic t_codes;
    logic [39:0] codes;
    integer i;
    codes = {`CMD_BLANK_CHECK, `CMD_BYTE_PROGRAM, `CMD_BURST_PROGRAM, `CMD_PAGE_ERASE,
             `CMD_MASS_ERASE};
    launch(`CMD_BLANK_CHECK, 16'h0000);
    wait_start;
    finish_cmd(1'b0);
    expect_reg(`OFS_STATUS, 32'hc0);
    check({30'h0, security_state}, 32'h0);
    debug_write(8'h01);
    expect_reg(`OFS_PROTECTION, 32'h01);
    apb(1'b1, `OFS_PROTECTION, 32'h00);
    expect_reg(`OFS_PROTECTION, 32'h01);
    for (i = 0; i < 5; i = i + 1) begin
      launch(codes[39-8*i -: 8], 16'hff00);
      wait_start;
      check({24'h0, array_command}, {24'h0, codes[39-8*i -: 8]});
      finish_cmd(1'b1);
      expect_reg(`OFS_STATUS, (i == 0) ? 32'hc4 : 32'hc0);
    end
    check({30'h0, security_state}, {30'h0, `SECURITY_UNSECURED});
    $display("command code test done");
  endtask
  task automatic t_burst_stop;
    launch(`CMD_BURST_PROGRAM, 16'h2000);
    wait_start;
    expect_reg(`OFS_STATUS, 32'h80);
    launch(`CMD_BURST_PROGRAM, 16'h2001);
    expect_reg(`OFS_STATUS, 32'h00);
    finish_cmd(1'b0);
    wait_start;
    check({16'h0, array_address}, 32'h2001);
    expect_reg(`OFS_STATUS, 32'h80);
    finish_cmd(1'b0);
    launch(`CMD_BYTE_PROGRAM, 16'h3000);
    wait_start;
    launch(`CMD_BYTE_PROGRAM, 16'h3001);
    expect_reg(`OFS_STATUS, 32'h90);
    @(posedge pclk);
    stop_entry <= 1'b1;
    @(posedge pclk);
    stop_entry <= 1'b0;
    @(negedge pclk);
    check({31'h0, array_abort}, 32'h1);
    expect_reg(`OFS_STATUS, 32'hd0);
    $display("burst and stop test done");
  endtask
  task automatic t_tick;
    integer n;
    apb(1'b1, `OFS_CLOCK_DIVIDER, 32'h42);
    expect_reg(`OFS_CLOCK_DIVIDER, 32'hc2);
    @(negedge pclk);
    while (flash_clock_tick !== 1'b1) @(negedge pclk);
    n = 0;
    do begin
      @(negedge pclk);
      n = n + 1;
    end while (flash_clock_tick !== 1'b1);
    check(n, 32'h18);
    launch(`CMD_MASS_ERASE, 16'h0000);
    wait_start;
    check({24'h0, array_command}, {24'h0, `CMD_MASS_ERASE});
    finish_cmd(1'b0);
    launch(`CMD_BYTE_PROGRAM, 16'h0100);
    wait_start;
    check({31'h0, seen}, 32'h1);
    check({24'h0, array_data}, 32'h5a);
    finish_cmd(1'b0);
    expect_reg(`OFS_STATUS, 32'hc0);
    $display("tick and erase test done");
  endtask
  task automatic t_reload;
    @(posedge pclk);
    nonvolatile_protection_copy <= 8'h3e;
    nonvolatile_security_copy   <= 2'h1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    expect_reg(`OFS_STATUS, 32'hc0);
    expect_reg(`OFS_PROTECTION, 32'h3e);
    check({30'h0, security_state}, 32'h1);
    $display("reload test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_errors;
    t_protection;
    t_codes;
    t_tick;
    t_burst_stop;
    t_reload;
    report_and_stop;
  end
  // The tests need well under 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    errors = errors + 1;
    report_and_stop;
  end
endmodule
`default_nettype wire
